// File: design/asrc_pkg.sv
package asrc_pkg;
  // address and data widths of the byte-wide memory
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  // clock period in picoseconds (50 MHz)
  localparam int CLK_PS = 20000;
  // pin timing figures in picoseconds, slowest speed grade
  localparam int WRITE_PULSE_MIN_PS              = 12000;
  localparam int ADDRESS_SETUP_TO_WRITE_END_PS   = 9000;
  localparam int DATA_SETUP_TO_WRITE_END_PS      = 7000;
  localparam int WRITE_TO_FLOAT_TIME_PS          = 5000;
  localparam int OUTPUT_ENABLE_TO_FLOAT_TIME_PS  = 6000;
  localparam int WRITE_RELEASE_TO_DRIVE_TIME_PS  = 2000;
  localparam int READ_ACCESS_PS                  = 12000;
  // minimum times round up to whole cycles, never below one
  function automatic int cyc_up(input int ps);
    int c;
    c = (ps + CLK_PS - 1) / CLK_PS;
    return (c < 1) ? 1 : c;
  endfunction
  localparam int WRITE_PULSE_CYC = cyc_up(WRITE_PULSE_MIN_PS + WRITE_TO_FLOAT_TIME_PS
                                          + DATA_SETUP_TO_WRITE_END_PS);
  localparam int ADDR_SETUP_CYC  = cyc_up(ADDRESS_SETUP_TO_WRITE_END_PS);
  localparam int OE_FLOAT_CYC    = cyc_up(OUTPUT_ENABLE_TO_FLOAT_TIME_PS);
  localparam int READ_CYC        = cyc_up(READ_ACCESS_PS) + 1;
  localparam int CNT_W           = 4;
  // request and pin image carriers
  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } asrc_req_t;
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic              cs_n;
    logic              oe_n;
    logic              we_n;
    logic [DATA_W-1:0] dout;
    logic              dout_en;
  } asrc_pins_t;
endpackage

// File: design/asrc_sync.sv
`timescale 1ns/1ps
// two-stage synchroniser for the data bus returning from the memory
module asrc_sync #(
  parameter int W = 8
) (
  input  wire logic         clock_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s1_nxt;
  logic [W-1:0] s2_nxt;

  // first stage feeds only the second
  always_comb begin
    s1_nxt = d_i;
    s2_nxt = s1_r;
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      s1_r <= '0;
      s2_r <= '0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
    end
  end

  assign q_o = s2_r;
endmodule

// File: design/asrc_ctrl.sv
`timescale 1ns/1ps
// How it works
// - address, data and select settle before write strobe falls.
// - data stays driven past the write strobe rising edge.
// - write pulse exceeds float time plus data setup when output enable low.
// - write strobe held low at least the slowest grade pulse time.
// - address stable long enough before write end.
// - read address is valid no later than select falling.
// - after output enable rises we wait its float time before driving.
module asrc_ctrl
  import asrc_pkg::*;
#(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W
) (
  input  wire logic               clock_i,
  input  wire logic               rst_n_i,
  input  wire asrc_pkg::asrc_req_t req_i,
  input  wire logic               req_valid_i,
  output logic                    req_ready_o,
  output logic [DW-1:0]           rdata_o,
  output logic                    rdata_valid_o,
  output logic                    write_done_o,
  output logic [AW-1:0]           sram_addr_o,
  output logic                    sram_cs_n_o,
  output logic                    sram_oe_n_o,
  output logic                    sram_we_n_o,
  output logic [DW-1:0]           sram_data_o,
  output logic                    sram_data_oe_o,
  input  wire logic [DW-1:0]      sram_data_i
);
  import asrc_pkg::*;

  // one transfer at a time; the select stays low for the whole of it
  typedef enum logic [2:0] {
    ST_IDLE,      // deselected, ready high, waiting for a request
    ST_RD,        // select and output enable low, byte settling
    ST_TURN,      // output enable high, memory may still drive
    ST_WR_SETUP,  // select, address and data out, write strobe high
    ST_WR_PULSE,  // write strobe low
    ST_WR_HOLD    // write strobe high again, data still driven
  } asrc_state_t;

  // sequencer state, the pin image it drives and the request it serves
  asrc_state_t      state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  asrc_pins_t       pins_r, pins_nxt;
  asrc_req_t        hold_r, hold_nxt;

  // answers to the requester, each one flop deep
  logic             ready_r, ready_nxt;
  logic [DW-1:0]    rdata_r, rdata_nxt;
  logic             rvalid_r, rvalid_nxt;
  logic             wdone_r, wdone_nxt;

  // read bus after the synchroniser
  logic [DW-1:0]    din_sync;

  // bus input crosses from the pins through two flops
  asrc_sync #(.W(DW)) u_sync (
    .clock_i (clock_i),
    .rst_n_i (rst_n_i),
    .d_i     (sram_data_i),
    .q_o     (din_sync)
  );

  // counter load value for a cycle count from the package
  function automatic logic [CNT_W-1:0] cnt_of(input int c);
    return CNT_W'(c);
  endfunction

  // strobes high and bus released, address left where it was; used at the
  // end of every transfer and when the state register holds an illegal code
  function automatic asrc_pins_t park(input asrc_pins_t p);
    asrc_pins_t r;
    r         = p;
    r.cs_n    = 1'b1;
    r.oe_n    = 1'b1;
    r.we_n    = 1'b1;
    r.dout_en = 1'b0;
    return r;
  endfunction

  // sequencer: one transfer at a time, strobes from flops only.
  // the cycle budget is fixed by the package counts: a read holds select and
  // output enable low for READ_CYC + 1 cycles, which covers the access time
  // and the two synchroniser stages; a write keeps the strobe low for
  // WRITE_PULSE_CYC + 1 cycles whatever output enable does, so a board that
  // ties output enable low later still meets the pulse and float limits
  always_comb begin
    state_nxt  = state_r;
    cnt_nxt    = cnt_r;
    pins_nxt   = pins_r;
    hold_nxt   = hold_r;
    ready_nxt  = 1'b0;
    rdata_nxt  = rdata_r;
    rvalid_nxt = 1'b0;
    wdone_nxt  = 1'b0;
    unique case (state_r)
      ST_IDLE: begin
        ready_nxt = 1'b1;
        if (req_valid_i && ready_r) begin
          hold_nxt      = req_i;
          ready_nxt     = 1'b0;
          pins_nxt.addr = req_i.addr;
          if (req_i.write) begin
            pins_nxt.cs_n    = 1'b0;
            pins_nxt.dout    = req_i.wdata;
            pins_nxt.dout_en = 1'b1;
            cnt_nxt          = cnt_of(ADDR_SETUP_CYC - 1);
            state_nxt        = ST_WR_SETUP;
          end else begin
            pins_nxt.cs_n = 1'b0;                   // address lands with select
            pins_nxt.oe_n = 1'b0;
            cnt_nxt       = cnt_of(READ_CYC);
            state_nxt     = ST_RD;
          end
        end
      end
      ST_RD: begin
        // wait access time plus sync latency; output enable holds bus
        pins_nxt.addr = hold_r.addr;                // address frozen while selected
        if (cnt_r == '0) begin
          rdata_nxt  = din_sync;
          rvalid_nxt = 1'b1;
          pins_nxt   = park(pins_r);                // output enable rises, bus floats
          cnt_nxt    = cnt_of(OE_FLOAT_CYC);
          state_nxt  = ST_TURN;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_TURN: begin
        // memory may still drive after output enable rises
        if (cnt_r == '0) begin
          state_nxt = ST_IDLE;
          ready_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_WR_SETUP: begin
        // address and data settle before the strobe
        pins_nxt.addr = hold_r.addr;
        pins_nxt.dout = hold_r.wdata;
        if (cnt_r == '0) begin
          pins_nxt.we_n = 1'b0;
          cnt_nxt       = cnt_of(WRITE_PULSE_CYC);
          state_nxt     = ST_WR_PULSE;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_WR_PULSE: begin
        // pulse covers float plus setup even with oe high
        // address and data may not move before the strobe rises
        pins_nxt.addr = hold_r.addr;
        pins_nxt.dout = hold_r.wdata;
        if (cnt_r == '0) begin
          pins_nxt.we_n = 1'b1;                     // write strobe ends the write
          state_nxt     = ST_WR_HOLD;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_WR_HOLD: begin
        // data held a cycle past the ending edge
        pins_nxt  = park(pins_r);                   // select rises, bus released
        wdone_nxt = 1'b1;
        state_nxt = ST_IDLE;
      end
      default: begin
        // illegal code: let go of the memory before anything else
        pins_nxt  = park(pins_r);
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // register stage; idle pins: deselected, strobes high, bus released
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state_r  <= ST_IDLE;
      cnt_r    <= '0;
      pins_r   <= '{addr: '0, cs_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, dout: '0, dout_en: 1'b0};
      hold_r   <= '0;
      ready_r  <= 1'b0;
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
      wdone_r  <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      cnt_r    <= cnt_nxt;
      pins_r   <= pins_nxt;
      hold_r   <= hold_nxt;
      ready_r  <= ready_nxt;
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      wdone_r  <= wdone_nxt;
    end
  end

  // handshake and answers straight from flops
  assign req_ready_o    = ready_r;
  assign rdata_o        = rdata_r;
  assign rdata_valid_o  = rvalid_r;
  assign write_done_o   = wdone_r;

  // pins straight from the registered image, so no glitch reaches a strobe
  assign sram_addr_o    = pins_r.addr;
  assign sram_cs_n_o    = pins_r.cs_n;
  assign sram_oe_n_o    = pins_r.oe_n;
  assign sram_we_n_o    = pins_r.we_n;
  assign sram_data_o    = pins_r.dout;
  assign sram_data_oe_o = pins_r.dout_en;
endmodule

// File: verif/asrc_ctrl_props.sv
`timescale 1ns/1ps
// pin and handshake checks
module asrc_ctrl_props
  import asrc_pkg::*;
(
  input wire logic                clock_i,
  input wire logic                rst_n_i,
  input wire asrc_pkg::asrc_req_t req_i,
  input wire logic                req_valid_i,
  input wire logic                req_ready_o,
  input wire logic                rdata_valid_o,
  input wire logic                write_done_o,
  input wire logic [ADDR_W-1:0]   sram_addr_o,
  input wire logic                sram_cs_n_o,
  input wire logic                sram_oe_n_o,
  input wire logic                sram_we_n_o,
  input wire logic                sram_data_oe_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  // a request is taken when both sides agree
  wire take = req_valid_i && req_ready_o;
  a_write_framed: assert property (!sram_we_n_o |->
    !sram_cs_n_o && sram_oe_n_o && sram_data_oe_o) else $error("strobe unframed");
  a_pulse_len: assert property ($fell(sram_we_n_o) |->
    !sram_we_n_o [*3] ##1 sram_we_n_o) else $error("pulse length");
  a_write_end: assert property ($rose(sram_we_n_o) |->
    sram_data_oe_o ##1 sram_cs_n_o && write_done_o) else $error("write end");
  a_addr_held: assert property (!sram_cs_n_o && !$fell(sram_cs_n_o) |->
    $stable(sram_addr_o)) else $error("address moved");
  a_oe_float: assert property ($rose(sram_oe_n_o) |->
    !sram_data_oe_o [*2]) else $error("early drive");
  a_no_fight: assert property (!sram_oe_n_o |->
    !sram_data_oe_o && sram_we_n_o) else $error("bus fight");
  a_read_time: assert property (take && !req_i.write |->
    ##[3:5] rdata_valid_o) else $error("read late");
  a_write_time: assert property (take && req_i.write |->
    ##[5:7] write_done_o) else $error("write late");
  c_read: cover property (rdata_valid_o);
  c_write: cover property (write_done_o);
  c_pulse: cover property ($fell(sram_we_n_o));
endmodule
bind asrc_ctrl asrc_ctrl_props u_props (.clock_i, .rst_n_i, .req_i, .req_valid_i,
  .req_ready_o, .rdata_valid_o, .write_done_o, .sram_addr_o, .sram_cs_n_o,
  .sram_oe_n_o, .sram_we_n_o, .sram_data_oe_o);

// File: verif/asrc_sram_model.sv
`timescale 1ns/1ps
// behavioural byte memory; zero delay, so it answers promptly
module asrc_sram_model
  import asrc_pkg::*;
(
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic              cs_n_i,
  input  wire logic              oe_n_i,
  input  wire logic              we_n_i,
  input  wire logic [DATA_W-1:0] data_i,
  output logic      [DATA_W-1:0] data_o = 8'h5A
);
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  wire               wr = !cs_n_i && !we_n_i;
  // store when the overlap ends, whichever strobe rises first
  always @(negedge wr) if (!$isunknown(addr_i)) mem[addr_i] = data_i;
  // undriven bus flips, so a stale byte never looks valid
  always @(addr_i or cs_n_i or oe_n_i or we_n_i)
    if (!cs_n_i && !oe_n_i && we_n_i) data_o = mem[addr_i];
    else data_o = ~data_o;
endmodule

// File: verif/testbench.sv
`timescale 1ns/1ps
module testbench;
  import asrc_pkg::*;
  logic              clock_i = 1'b0;
  logic              rst_n_i = 1'b0;
  logic              vld = 1'b0;
  asrc_req_t         req = '0;
  logic              rdy, rv, wd, cs_n, oe_n, we_n, doe;
  logic [DATA_W-1:0] rdata, dout, mdata, q;
  logic [ADDR_W-1:0] addr;
  logic [ADDR_W-1:0] ends [3] = '{18'h00000, 18'h3FFFF, 18'h2AAAA};
  int                errors = 0;
  int                comparisons = 0;
  wire  [DATA_W-1:0] bus = doe ? dout : mdata;
  always #10 clock_i = ~clock_i;
  asrc_ctrl u_asrc_ctrl (.clock_i, .rst_n_i, .req_i(req), .req_valid_i(vld), .req_ready_o(rdy),
    .rdata_o(rdata), .rdata_valid_o(rv), .write_done_o(wd), .sram_addr_o(addr),
    .sram_cs_n_o(cs_n), .sram_oe_n_o(oe_n), .sram_we_n_o(we_n), .sram_data_o(dout),
    .sram_data_oe_o(doe), .sram_data_i(bus));
  asrc_sram_model u_asrc_sram_model (.addr_i(addr), .cs_n_i(cs_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .data_i(bus), .data_o(mdata));
  task automatic cmp(input string n, input logic [7:0] e, input logic [7:0] s);
    comparisons++;
    if (s !== e) begin
      errors++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  // hold one request until taken, then wait a bounded time for its answer
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n = 0;
    @(posedge clock_i);
    req <= '{w, a, d};
    vld <= 1'b1;
    do @(negedge clock_i); while (rdy !== 1'b1 && ++n < 40);
    @(posedge clock_i);
    vld <= 1'b0;
    do @(negedge clock_i); while ((w ? wd : rv) !== 1'b1 && ++n < 80);
    q = rdata;
    cmp("answer", 8'h01, {7'h00, w ? wd : rv});
  endtask
  // back to back writes at both address ends and at 18'h2AAAA, then reads in a row
  task automatic t_ends();
    for (int i = 0; i < 3; i++) xfer(1'b1, ends[i], 8'hA0 + 8'(i));
    for (int i = 0; i < 3; i++) begin
      xfer(1'b0, ends[i], 8'h00);
      cmp("rdata", 8'hA0 + 8'(i), q);
    end
  endtask
  task automatic t_over();
    xfer(1'b1, 18'h12345, 8'h3C);
    xfer(1'b1, 18'h12345, 8'hC3);
    xfer(1'b0, 18'h12345, 8'h00);
    cmp("rdata", 8'hC3, q);
  endtask
  // reset with the write strobe low must drop it and float the bus
  task automatic t_abort();
    int n = 0;
    @(posedge clock_i);
    req <= '{1'b1, 18'h00777, 8'h11};
    vld <= 1'b1;
    do @(negedge clock_i); while (we_n !== 1'b0 && ++n < 40);
    cmp("we_n low", 8'h00, {7'h00, we_n});
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    vld <= 1'b0;
    @(posedge clock_i);
    @(negedge clock_i);
    cmp("we_n", 8'h01, {7'h00, we_n});
    cmp("data_oe", 8'h00, {7'h00, doe});
    cmp("cs_n", 8'h01, {7'h00, cs_n});
    @(posedge clock_i);
    rst_n_i <= 1'b1;
    xfer(1'b0, 18'h3FFFF, 8'h00);
    cmp("rdata", 8'hA1, q);
  endtask
  task automatic close_out();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clock_i);
    rst_n_i <= 1'b1;
    t_ends();
    t_over();
    t_abort();
    close_out();
  end
  // the whole run needs about seventy-five cycles
  initial begin
    repeat (2000) @(posedge clock_i);
    errors++;
    close_out();
  end
endmodule
